/* inc/synth_cfg_pkg.sv */
// Constants shared by the synthesizer mode and fast-calibration block.
// Assumes a 50 MHz system clock.
package synth_cfg_pkg;
  // Clock period in picoseconds.
  localparam int unsigned CLK_PERIOD_PS = 20000;
  // Fast calibration time in nanoseconds.
  localparam int unsigned FASTCAL_TIME_NS = 2500;
  // Longest time rounds down to whole cycles.
  localparam int unsigned FASTCAL_CYCLES = (FASTCAL_TIME_NS * 1000) / CLK_PERIOD_PS;
  // Width of the calibration timeout count.
  localparam int unsigned TIMEOUT_W = 16;
  // Reset values.
  localparam logic [2:0] RST_BAND = 3'h0;
  localparam logic [7:0] RST_BIAS = 8'h00;
  localparam logic [7:0] RST_CAP = 8'h00;
  // Calibration clock divider width.
  localparam int unsigned CAL_DIV_W = 3;
  // Feedback mode codes.
  localparam logic [1:0] FB_INTERNAL = 2'h0;
  localparam logic [1:0] FB_PHASE_PIN = 2'h1;
  localparam logic [1:0] FB_RF_INPUT = 2'h2;
  // Smallest divide ratio on each external feedback path.
  localparam logic [11:0] MIN_DIV_PHASE = 12'h001;
  localparam logic [11:0] MIN_DIV_RF = 12'h004;
  // Calibration controller states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FULL,
    ST_FAST
  } cal_state_type;
endpackage

/* logic/fastcal_timer.sv */
// Timeout counter for the calibration sequence.
// Assumes start is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module fastcal_timer
  import synth_cfg_pkg::*;
#(
  parameter int unsigned W = TIMEOUT_W
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [W-1:0] i_load,
  output logic o_busy,
  output logic o_done
);
  typedef struct packed {
    logic [W-1:0] count;
    logic busy;
    logic done;
  } timer_state_type;
  timer_state_type st;
  timer_state_type next_st;

  // Loads the count on start and pulses done in the cycle after it reaches one or less.
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (i_start) begin
      next_st.count = i_load;
      next_st.busy = 1'b1;
    end else if (st.busy) begin
      if (st.count <= {{(W-1){1'b0}}, 1'b1}) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.count = st.count - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Registers the state.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_busy = st.busy;
  assign o_done = st.done;
endmodule // fastcal_timer

/* logic/synth_mode_fastcal.sv */
// Mode decode and instant VCO calibration control of the synthesizer.
// Assumes the host presents register fields as plain ports on i_clk_sys.
`timescale 1ns/1ps
module synth_mode_fastcal
  import synth_cfg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ext_vco_mode,
  input wire logic [1:0] i_feedback_mode,
  input wire logic [1:0] i_single_pfd_select,
  input wire logic [11:0] i_ext_pfd_divider,
  input wire logic i_fractional_en,
  input wire logic i_fastcal_enable,
  input wire logic i_fastcal_doubler_flag,
  input wire logic [TIMEOUT_W-1:0] i_fastcal_timeout_count,
  input wire logic i_config_word_zero_wr,
  input wire logic i_vco_cal_trigger,
  input wire logic i_doubler_cal_enable,
  input wire logic [2:0] i_found_band,
  input wire logic [7:0] i_found_bias,
  input wire logic [7:0] i_found_cap,
  output logic o_rf_buffers_enable,
  output logic o_sysref_enable,
  output logic o_single_pfd_active,
  output logic o_divider_ok,
  output logic o_cal_busy,
  output logic o_cal_done,
  output logic o_fastcal_valid,
  output logic [2:0] o_vco_band,
  output logic [7:0] o_vco_bias,
  output logic [7:0] o_vco_cap,
  output logic o_doubler_stored
);
  typedef struct packed {
    cal_state_type state;
    logic en_d;
    logic valid;
    logic [2:0] band;
    logic [7:0] bias;
    logic [7:0] cap;
    logic dbl;
    logic [7:0] fast_cnt;
    logic busy;
    logic done;
    logic rf_buf;
    logic sysref;
    logic single_pfd;
    logic div_ok;
  } cal_regs_type;
  cal_regs_type r;
  cal_regs_type next_r;

  logic timer_start;
  logic timer_busy;
  logic timer_done;

  // Returns whether the divider ratio is legal for the selected feedback path.
  function automatic logic div_legal(input logic [1:0] mode, input logic [11:0] div);
    if (mode == FB_PHASE_PIN) begin
      div_legal = (div >= MIN_DIV_PHASE);
    end else if (mode == FB_RF_INPUT) begin
      div_legal = (div >= MIN_DIV_RF);
    end else begin
      div_legal = 1'b1;
    end
  endfunction

  // A full calibration is timed by the host-programmed timeout count.
  assign timer_start = i_config_word_zero_wr && i_vco_cal_trigger && !r.valid
                       && i_fastcal_enable && r.en_d && r.state == ST_IDLE;

  fastcal_timer #(
    .W(TIMEOUT_W)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_start(timer_start),
    .i_load(i_fastcal_timeout_count),
    .o_busy(timer_busy),
    .o_done(timer_done)
  );

  // Mode decode and calibration sequencing.
  always_comb begin
    next_r = r;
    next_r.en_d = i_fastcal_enable;
    next_r.done = 1'b0;
    next_r.rf_buf = !i_ext_vco_mode;
    next_r.sysref = 1'b1;
    // Phase pin feedback only runs with single detector selected; RF input needs none.
    next_r.single_pfd = (i_feedback_mode == FB_PHASE_PIN) && (i_single_pfd_select == 2'h3);
    next_r.div_ok = div_legal(i_feedback_mode, i_ext_pfd_divider)
                    && !(i_feedback_mode == FB_PHASE_PIN && i_fractional_en);
    case (r.state)
      ST_IDLE: begin
        if (i_config_word_zero_wr && !(i_fastcal_enable && !r.en_d)) begin
          if (timer_start) begin
            next_r.state = ST_FULL;
            next_r.busy = 1'b1;
          end else if (r.valid && i_fastcal_enable && !i_doubler_cal_enable
                       && !i_vco_cal_trigger) begin
            next_r.state = ST_FAST;
            next_r.busy = 1'b1;
            next_r.fast_cnt = 8'(FASTCAL_CYCLES - 1);
          end
        end
      end
      ST_FULL: begin
        if (timer_done) begin
          // Capture the found settings; band, bias and cap kept until system reset or re-arm, dbl until system reset or the next capture.
          next_r.valid = 1'b1;
          next_r.band = i_found_band;
          next_r.bias = i_found_bias;
          next_r.cap = i_found_cap;
          next_r.dbl = i_fastcal_doubler_flag;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.state = ST_IDLE;
        end
      end
      ST_FAST: begin
        if (r.fast_cnt == 8'h00) begin
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.state = ST_IDLE;
        end else begin
          next_r.fast_cnt = r.fast_cnt - 8'h01;
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
    // A rising enable discards the stored valid, band, bias and cap but not dbl; it comes last so it beats a capture.
    if (i_fastcal_enable && !r.en_d) begin
      next_r.valid = 1'b0;
      next_r.band = RST_BAND;
      next_r.bias = RST_BIAS;
      next_r.cap = RST_CAP;
    end
  end

  // Registers the whole state.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_rf_buffers_enable = r.rf_buf;
  assign o_sysref_enable = r.sysref;
  assign o_single_pfd_active = r.single_pfd;
  assign o_divider_ok = r.div_ok;
  assign o_cal_busy = r.busy;
  assign o_cal_done = r.done;
  assign o_fastcal_valid = r.valid;
  assign o_vco_band = r.band;
  assign o_vco_bias = r.bias;
  assign o_vco_cap = r.cap;
  assign o_doubler_stored = r.dbl;

  // Buffers follow the VCO mode one cycle later.
  AST_BUF_OFF: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ext_vco_mode |=> !o_rf_buffers_enable) else $error("Buffers on in ext VCO mode.");
  AST_SYSREF_ON: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(!i_sys_rst) |-> o_sysref_enable) else $error("Sysref dropped.");
  AST_DIV_ONE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_feedback_mode == FB_PHASE_PIN && i_ext_pfd_divider == 12'h001 && !i_fractional_en)
    |=> o_divider_ok) else $error("Divide by one refused.");
  AST_RF_FRAC: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_feedback_mode == FB_RF_INPUT && i_ext_pfd_divider >= MIN_DIV_RF)
    |=> o_divider_ok) else $error("RF feedback refused.");
  AST_FAST_TIME: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (r.state == ST_IDLE && next_r.state == ST_FAST) |-> ##[125:126] o_cal_done)
    else $error("Fast calibration late.");
  AST_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(i_fastcal_enable) |=> !o_fastcal_valid) else $error("Settings not cleared.");
  AST_KEEP: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (o_fastcal_valid && i_fastcal_enable && $past(i_fastcal_enable))
    |=> $stable(o_vco_band)) else $error("Stored band lost.");
  AST_FULL_SET: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    timer_start |=> o_cal_busy && !o_fastcal_valid)
    else $error("Full calibration not started.");
  AST_TIMER_IDLE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (r.state != ST_FULL) |-> !timer_busy) else $error("Timer runs outside full calibration.");

  COV_FULL: cover property (@(posedge i_clk_sys) r.state == ST_FULL && timer_done);
  COV_FAST: cover property (@(posedge i_clk_sys) r.state == ST_FAST && r.fast_cnt == 8'h00);
  COV_REARM: cover property (@(posedge i_clk_sys) $rose(i_fastcal_enable) && o_fastcal_valid);
endmodule // synth_mode_fastcal

/* tb/synth_host_model.sv */
// Host controller model that writes configuration word zero to the synthesizer.
// Assumes the device takes a write on a rising edge and answers with a done pulse.
`timescale 1ns/1ps
module synth_host_model (
  input wire logic i_clk_sys,
  input wire logic i_cal_done,
  output logic o_config_word_zero_wr,
  output logic o_vco_cal_trigger,
  output logic o_doubler_cal_enable
);
  // The write strobe is idle from time zero.
  initial begin
    o_config_word_zero_wr = 1'b0;
    o_vco_cal_trigger = 1'b0;
    o_doubler_cal_enable = 1'b0;
  end

  // Word zero goes last, so it starts the calibration; n is 0 if no done came.
  task automatic write_word(input logic trig, input logic dbl, input int max_wait,
                            output int n);
    @(negedge i_clk_sys);
    o_config_word_zero_wr = 1'b1;
    o_vco_cal_trigger = trig;
    o_doubler_cal_enable = dbl;
    @(negedge i_clk_sys);
    o_config_word_zero_wr = 1'b0;
    o_vco_cal_trigger = ~trig; // Stale bits no longer hold their value.
    o_doubler_cal_enable = ~dbl;
    n = 0;
    for (int k = 1; k <= max_wait && n == 0; k++) begin
      @(negedge i_clk_sys);
      if (i_cal_done === 1'b1) n = k;
    end
  endtask

  // Delay word for an external VCO: base by modulator order, one more per 1.5 GHz band.
  function automatic int pfd_delay_word(input int fin_mhz, input int order);
    int base;
    int band_step;
    base = (order == 3) ? 4 : (order == 2) ? 2 : 1;
    band_step = (fin_mhz <= 4000) ? 0 : (fin_mhz > 10000) ? 5 : (fin_mhz - 2501) / 1500;
    pfd_delay_word = base + band_step;
  endfunction

  // The feedback divider is needed only above the top of the VCO range.
  function automatic logic ext_vco_div(input int fvco_mhz);
    ext_vco_div = (fvco_mhz > 11300);
  endfunction

  // The delay word is honoured only with the override set in external VCO mode.
  function automatic logic pfd_delay_override(input logic ext_vco);
    pfd_delay_override = ext_vco;
  endfunction

  // Shortest calibration delay in ns for a bias capacitor given in nF.
  function automatic int min_delay_ns(input int cap_nf);
    min_delay_ns = 2500 * cap_nf / 470;
  endfunction

  // Timeout count from delay, reference frequency and calibration clock divider.
  function automatic int cal_timeout(input int dly_ns, input int fosc_mhz, input int div);
    cal_timeout = (dly_ns * fosc_mhz / 1000) >> div;
  endfunction

  // Fraction word as two to the 32 times numerator over denominator.
  function automatic longint fraction_word(input longint num, input longint den);
    fraction_word = (num << 32) / den;
  endfunction
endmodule // synth_host_model

/* tb/synth_mode_and_fastcal_config_tb.sv */
// Self-checking bench for the mode decode and fast calibration control.
// Assumes inputs change at the falling edge and outputs settle before it.
`timescale 1ns/1ps
`define check_eq(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module synth_mode_and_fastcal_config_tb;
  import synth_cfg_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ext_vco = 1'b0, frac_en = 1'b0, fc_en = 1'b0, fc_dbl = 1'b1;
  logic [1:0] fb_mode = 2'h0, pfd_sel = 2'h0;
  logic [11:0] pfd_div = 12'h000;
  logic [15:0] tmo = 16'h000a;
  logic [2:0] band = 3'h5, vband;
  logic [7:0] bias = 8'ha5, cap = 8'h3c, vbias, vcap;
  logic wr, trig, dbl, rf_en, sysref, single, div_ok, busy, done, valid, dstored;
  int miscompares = 0, checks_done = 0, n, t;

  synth_mode_fastcal u_synth_mode_fastcal (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_ext_vco_mode(ext_vco), .i_feedback_mode(fb_mode), .i_single_pfd_select(pfd_sel),
    .i_ext_pfd_divider(pfd_div), .i_fractional_en(frac_en), .i_fastcal_enable(fc_en),
    .i_fastcal_doubler_flag(fc_dbl), .i_fastcal_timeout_count(tmo),
    .i_config_word_zero_wr(wr), .i_vco_cal_trigger(trig), .i_doubler_cal_enable(dbl),
    .i_found_band(band), .i_found_bias(bias), .i_found_cap(cap), .o_rf_buffers_enable(rf_en),
    .o_sysref_enable(sysref), .o_single_pfd_active(single), .o_divider_ok(div_ok),
    .o_cal_busy(busy), .o_cal_done(done), .o_fastcal_valid(valid), .o_vco_band(vband),
    .o_vco_bias(vbias), .o_vco_cap(vcap), .o_doubler_stored(dstored));

  synth_host_model u_synth_host_model (.i_clk_sys(clk), .i_cal_done(done),
    .o_config_word_zero_wr(wr), .o_vco_cal_trigger(trig), .o_doubler_cal_enable(dbl));

  // Free-running system clock at 50 MHz.
  initial begin
    forever #10 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Applies a mode setting and checks the decode two cycles later.
  task automatic mode(input logic ev, input logic [1:0] fm, input logic [1:0] sel,
                      input logic [11:0] dv, input logic fr, input logic e_sg, input logic e_ok);
    @(negedge clk);
    {ext_vco, fb_mode, pfd_sel, pfd_div, frac_en} = {ev, fm, sel, dv, fr};
    repeat (2) @(negedge clk);
    `check_eq("rf_buffers", ~ev, rf_en)
    `check_eq("sysref", 1'b1, sysref)
    `check_eq("single_pfd", e_sg, single)
    `check_eq("divider_ok", e_ok, div_ok)
  endtask

  // Checks the stored calibration settings.
  task automatic stored(input logic [2:0] b, input logic [7:0] bi, input logic [7:0] c);
    `check_eq("band", b, vband)
    `check_eq("bias", bi, vbias)
    `check_eq("cap", c, vcap)
  endtask

  // Watchdog sized well above the few hundred cycles the tests need.
  initial begin
    #(20 * 3000);
    miscompares++;
    complete_run();
  end

  // Main test sequence.
  initial begin
    t = u_synth_host_model.min_delay_ns(470);
    tmo = 16'(u_synth_host_model.cal_timeout(t, 128, 5));
    repeat (2) @(negedge clk);
    `check_eq("rst_sysref", 1'b0, sysref)
    `check_eq("rst_valid", 1'b0, valid)
    rst = 1'b0;
    `check_eq("dly_lo", 4, u_synth_host_model.pfd_delay_word(3000, 3))
    `check_eq("dly_mid", 4, u_synth_host_model.pfd_delay_word(6000, 2))
    `check_eq("dly_hi", 9, u_synth_host_model.pfd_delay_word(12000, 3))
    `check_eq("vco_div", 1'b1, u_synth_host_model.ext_vco_div(11400))
    `check_eq("vco_nodiv", 1'b0, u_synth_host_model.ext_vco_div(11300))
    `check_eq("dly_override", 1'b1, u_synth_host_model.pfd_delay_override(1'b1))
    t = u_synth_host_model.min_delay_ns(4700);
    `check_eq("tmo_4u7", 100, u_synth_host_model.cal_timeout(t, 128, 5))
    `check_eq("frac_word", 64'h40000000, u_synth_host_model.fraction_word(64'h1, 64'h4))
    mode(1'b1, FB_INTERNAL, 2'h0, 12'h000, 1'b0, 1'b0, 1'b1);
    mode(1'b0, FB_PHASE_PIN, 2'h3, 12'h001, 1'b0, 1'b1, 1'b1);
    mode(1'b0, FB_PHASE_PIN, 2'h2, 12'h001, 1'b0, 1'b0, 1'b1);
    mode(1'b0, FB_PHASE_PIN, 2'h3, 12'h000, 1'b0, 1'b1, 1'b0);
    mode(1'b0, FB_RF_INPUT, 2'h0, 12'h003, 1'b1, 1'b0, 1'b0);
    mode(1'b0, FB_RF_INPUT, 2'h0, 12'h004, 1'b1, 1'b0, 1'b1);
    mode(1'b0, FB_PHASE_PIN, 2'h3, 12'h001, 1'b1, 1'b1, 1'b0);
    fc_en = 1'b1;
    @(negedge clk);
    u_synth_host_model.write_word(1'b1, 1'b0, 40, n);
    `check_eq("full_lat", 1'b1, (n >= 11 && n <= 12))
    `check_eq("valid", 1'b1, valid)
    `check_eq("dbl_stored", 1'b1, dstored)
    stored(3'h5, 8'ha5, 8'h3c);
    {band, bias, cap} = {3'h2, 8'h5a, 8'hc3};
    repeat (2) begin
      fork
        u_synth_host_model.write_word(1'b0, 1'b0, 200, n);
        begin
          repeat (3) @(negedge clk);
          `check_eq("busy", 1'b1, busy)
        end
      join
      `check_eq("fast_lat", 1'b1, (n >= 125 && n <= 126))
      `check_eq("busy_end", 1'b0, busy)
      stored(3'h5, 8'ha5, 8'h3c);
    end
    u_synth_host_model.write_word(1'b1, 1'b0, 30, n);
    `check_eq("retrig_refused", 0, n)
    u_synth_host_model.write_word(1'b0, 1'b1, 150, n);
    `check_eq("dblcal_refused", 0, n)
    stored(3'h5, 8'ha5, 8'h3c);
    fc_en = 1'b0;
    @(negedge clk);
    fc_en = 1'b1;
    repeat (2) @(negedge clk);
    `check_eq("cleared", 1'b0, valid)
    stored(RST_BAND, RST_BIAS, RST_CAP);
    u_synth_host_model.write_word(1'b0, 1'b0, 150, n);
    `check_eq("fast_no_init", 0, n)
    {tmo, fc_dbl} = {16'h0000, 1'b0};
    u_synth_host_model.write_word(1'b1, 1'b0, 20, n);
    `check_eq("tmo0_lat", 1'b1, (n >= 2 && n <= 3))
    `check_eq("dbl_stored", 1'b0, dstored)
    stored(3'h2, 8'h5a, 8'hc3);
    complete_run();
  end
endmodule // synth_mode_and_fastcal_config_tb
